// File: logic/compute_pkg.sv
// Shared constants and types of the fixed-point compute units.
package compute_pkg;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 4;
   localparam int ACC_W = 40;
   localparam int PROD_W = 32;
   localparam int EXPO_W = 8;
   localparam int MMODE_BIT = 4;
   localparam logic [DATA_W-1:0] WORD_ZERO = 16'h0000;
   localparam logic [ACC_W-1:0] ACC_ZERO = 40'h00_0000_0000;
   localparam logic [ACC_W-1:0] ROUND_ADD = 40'h00_0000_8000;
   localparam logic [EXPO_W-1:0] EXPO_ZERO = 8'h00;

   // Unit selected by an instruction; U_NOP is the all-zero code.
   typedef enum logic [2:0] {U_NOP, U_ALU, U_MUL, U_SHIFT, U_MOVE, U_LOAD, U_STORE} unit_e;
   typedef enum logic [2:0] {A_ADD, A_ADDC, A_SUB, A_AND, A_OR, A_XOR, A_NOT, A_PASS} alu_op_e;
   typedef enum logic [1:0] {M_MUL, M_MAC, M_MSUB} mul_op_e;
   typedef enum logic [1:0] {S_LSH, S_ASH, S_EXP} shift_op_e;
   // X operand source; results bus entries plus the two shifter-only registers.
   typedef enum logic [3:0]
   {
      X_REG, X_MR_TOP, X_MR_MID, X_MR_LOW, X_SR_MID, X_SR_LOW, X_AR, X_SB, X_SE
   } src_e;
   typedef enum logic [1:0] {D_REG, D_SB, D_SE} move_dst_e;
   typedef enum logic {B_DM, B_PM} bus_e;

   // One computational or move instruction from the sequencer.
   typedef struct packed
   {
      unit_e unit;
      alu_op_e alu_op;
      mul_op_e mul_op;
      shift_op_e shift_op;
      src_e x_src;
      move_dst_e move_dst;
      bus_e bus;
      logic x_signed;
      logic y_signed;
      logic round;
      logic alt_dst;
      logic [ADDR_W-1:0] x_reg;
      logic [ADDR_W-1:0] y_reg;
      logic [ADDR_W-1:0] d_reg;
   } instr_s;

   // Arithmetic status flags.
   typedef struct packed
   {
      logic alu_zero_flag;
      logic alu_negative_flag;
      logic alu_overflow_flag;
      logic alu_carry_flag;
   } flags_s;

   typedef struct packed
   {
      logic [DATA_W-1:0] result;
      flags_s flags;
   } alu_out_s;
endpackage

// File: logic/regfile_mem.sv
`timescale 1ns/1ps
// Banked data register file with registered, write-first read ports.
module regfile_mem
#(
   parameter int WIDTH = 16,
   parameter int AW = 5
)
(
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst_n,
   // Write port.
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [WIDTH-1:0] wdata,
   // Read ports.
   input wire logic [AW-1:0] raddr_a,
   input wire logic [AW-1:0] raddr_b,
   output logic [WIDTH-1:0] rdata_a,
   output logic [WIDTH-1:0] rdata_b
);
   logic [WIDTH-1:0] mem [2**AW];

   // Storage has no reset so it can map onto a plain memory.
   always_ff @(posedge ref_clk)
   begin
      if (we)
      begin
         mem[waddr] <= wdata;
      end
   end

   // Write-first reads: a word written at this edge is seen at once.
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         rdata_a <= '0;
         rdata_b <= '0;
      end
      else
      begin
         rdata_a <= (we && waddr == raddr_a) ? wdata : mem[raddr_a];
         rdata_b <= (we && waddr == raddr_b) ? wdata : mem[raddr_b];
      end
   end
endmodule

// File: logic/fixed_point_compute_units.sv
`timescale 1ns/1ps
// ALU, multiplier and shifter datapath with banked registers and results bus.
// Notes on behaviour
// - Each computation finishes in one cycle.
// - MR, AR and lower SR parts feed any unit next cycle.
// - Sixteen-word banked file, memory bus ports.
// - Result registers selectable as X operand.
// - Shift result top never fed back.
// - Top parts read 16 bits, hold 8.
// - Exponent registers move only, shifter-only inputs.
// - Secondary copies of file and result registers.
// - Modes from mode word, flags to status.
// - Signed values are two's complement only.
// - Logic operations treat bits as patterns.
// - ALU strings; flags read result as signed.
// - Overflow on unexpected sign; mixed-sign add never.
// - Carry flag from unsigned carry out.
// - Multiplier operand signedness chosen per instruction.
// - Product sign-extended across 40 bits.
// - Fractional mode shifts product left once.
// - Integer mode keeps product unshifted.
// - 1.15 format spans -1 to under +1.
// - Logical shifts unsigned, arithmetic shifts signed.
// - Exponent detect reads two's complement input.
// - Lower words of multiword values unsigned.
// - Mode bit four selects multiplier format.
module fixed_point_compute_units
#(
   parameter int REGS = 16
)
(
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst_n,
   // Instruction issue and modes.
   input compute_pkg::instr_s instr,
   input wire logic secondary_sel,
   input wire logic [compute_pkg::DATA_W-1:0] mode_status_reg,
   // Memory data buses.
   input wire logic [compute_pkg::DATA_W-1:0] pm_data_in,
   input wire logic [compute_pkg::DATA_W-1:0] dm_data_in,
   output logic [compute_pkg::DATA_W-1:0] bus_data_out,
   output logic bus_data_valid,
   output compute_pkg::bus_e bus_data_sel,
   // Results and status.
   output compute_pkg::flags_s arith_status_reg,
   output logic [compute_pkg::ACC_W-1:0] multiply_result,
   output logic [compute_pkg::ACC_W-1:0] shift_result,
   output logic [compute_pkg::DATA_W-1:0] alu_result,
   output logic [compute_pkg::DATA_W-1:0] alu_feedback,
   output logic [compute_pkg::EXPO_W-1:0] shift_exponent,
   output logic [compute_pkg::EXPO_W-1:0] shift_block_exponent
);
   import compute_pkg::*;

   instr_s ex;
   logic ex_bank, cur_bank, swap, we, add_carry;
   logic [ADDR_W:0] waddr;
   logic [DATA_W-1:0] rd_x, rd_y, x_op, y_op, wdata, move_val, alu_res;
   logic [DATA_W-1:0] next_ar, next_af, ar_alt, af_alt;
   logic [ACC_W-1:0] next_mr, next_sr, mr_alt, sr_alt, mul_full, acc;
   logic [EXPO_W-1:0] next_se, next_sb, se_alt, sb_alt;
   logic [ADDR_W-1:0] ex_dreg;
   logic [DATA_W:0] add_chk;
   logic signed [PROD_W-1:0] prod_chk;
   flags_s next_flags;
   alu_out_s alu_out;

   if (REGS != 2**ADDR_W)
   begin : g_check
      $error("REGS must match the register address width");
   end

   ////////////////////////////////////////////////////////////////////////////
   // ALU with flags: sixteen-bit strings, flags read the result as signed.
   function automatic alu_out_s alu_calc(alu_op_e op, logic [DATA_W-1:0] x,
      logic [DATA_W-1:0] y, logic cin);
      alu_out_s o;
      logic [DATA_W:0] sum;
      o = '0;
      sum = '0;
      unique case (op)
         A_ADD: sum = {1'b0, x} + {1'b0, y};
         // carry chaining: upper words add with the carry in from the unsigned lower words.
         A_ADDC: sum = {1'b0, x} + {1'b0, y} + {{DATA_W{1'b0}}, cin};
         A_SUB: sum = {1'b0, x} + {1'b0, ~y} + 17'h0_0001;
         A_AND: sum = {1'b0, x & y};
         A_OR: sum = {1'b0, x | y};
         A_XOR: sum = {1'b0, x ^ y};
         A_NOT: sum = {1'b0, ~x};
         A_PASS: sum = {1'b0, x};
      endcase
      o.result = sum[DATA_W-1:0];
      o.flags.alu_zero_flag = (o.result == WORD_ZERO);
      o.flags.alu_negative_flag = o.result[DATA_W-1];
      // overflow by signs: same-sign add or mixed-sign subtract only.
      if (op == A_ADD || op == A_ADDC)
      begin
         o.flags.alu_overflow_flag = (x[DATA_W-1] == y[DATA_W-1]) &&
            (o.result[DATA_W-1] != x[DATA_W-1]);
         o.flags.alu_carry_flag = sum[DATA_W];
      end
      else if (op == A_SUB)
      begin
         o.flags.alu_overflow_flag = (x[DATA_W-1] != y[DATA_W-1]) &&
            (o.result[DATA_W-1] != x[DATA_W-1]);
         o.flags.alu_carry_flag = sum[DATA_W];
      end
      return o;
   endfunction

   // per-instruction signedness; each operand gets a seventeenth bit.
   function automatic logic [ACC_W-1:0] mul_calc(logic [DATA_W-1:0] x,
      logic [DATA_W-1:0] y, logic xs, logic ys, logic frac);
      logic signed [DATA_W:0] sx;
      logic signed [DATA_W:0] sy;
      logic signed [2*DATA_W+1:0] p;
      logic [ACC_W-1:0] e;
      sx = signed'({xs & x[DATA_W-1], x});
      sy = signed'({ys & y[DATA_W-1], y});
      p = sx * sy;
      // sign extension of the 32-bit product.
      e = {{(ACC_W-PROD_W){p[PROD_W-1]}}, p[PROD_W-1:0]};
      return frac ? {e[ACC_W-2:0], 1'b0} : e;
   endfunction

   // exponent detect: negated count of redundant sign bits.
   function automatic logic [EXPO_W-1:0] exp_detect(logic [DATA_W-1:0] x);
      logic [EXPO_W-1:0] n;
      logic run;
      n = EXPO_ZERO;
      run = 1'b1;
      for (int i = DATA_W - 2; i >= 0; i--)
      begin
         run = run & (x[i] == x[DATA_W-1]);
         n = n + {{(EXPO_W-1){1'b0}}, run};
      end
      return EXPO_ZERO - n;
   endfunction

   // shifts: positive amount shifts left, negative shifts right.
   function automatic logic [ACC_W-1:0] shift_calc(logic [DATA_W-1:0] x,
      logic [EXPO_W-1:0] se, logic arith);
      logic signed [ACC_W-1:0] v;
      logic [EXPO_W-1:0] mag;
      v = arith ? ACC_W'(signed'(x)) : {{(ACC_W-DATA_W){1'b0}}, x};
      mag = se[EXPO_W-1] ? EXPO_ZERO - se : se;
      if (!se[EXPO_W-1])
      begin
         return v << mag;
      end
      return arith ? v >>> mag : v >> mag;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // banked data file; bank bit on top so both banks share one array.
   regfile_mem #(.WIDTH(DATA_W), .AW(ADDR_W + 1)) u_regs
   (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .we(we),
      .waddr(waddr),
      .wdata(wdata),
      .raddr_a({secondary_sel, instr.x_reg}),
      .raddr_b({secondary_sel, instr.y_reg}),
      .rdata_a(rd_x),
      .rdata_b(rd_y)
   );

   // Instruction enters execution while its file operands are being read.
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         ex <= instr_s'('0);
         ex_bank <= 1'b0;
      end
      else
      begin
         ex <= instr;
         ex_bank <= secondary_sel;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // next-cycle result feedback.
   // results bus X selection; no entry exists for the shift result top.
   always_comb
   begin
      y_op = rd_y;
      unique case (ex.x_src)
         // top parts read back as 16 bits, sign-extended from 8.
         X_MR_TOP: x_op = {{(DATA_W-EXPO_W){multiply_result[ACC_W-1]}},
            multiply_result[ACC_W-1:PROD_W]};
         X_MR_MID: x_op = multiply_result[PROD_W-1:DATA_W];
         X_MR_LOW: x_op = multiply_result[DATA_W-1:0];
         X_SR_MID: x_op = shift_result[PROD_W-1:DATA_W];
         X_SR_LOW: x_op = shift_result[DATA_W-1:0];
         X_AR: x_op = alu_result;
         // exponent registers never reach a unit operand.
         default: x_op = rd_x;
      endcase
   end

   // moves from the exponent registers into the data file.
   always_comb
   begin
      unique case (ex.x_src)
         X_SB: move_val = {{(DATA_W-EXPO_W){shift_block_exponent[EXPO_W-1]}},
            shift_block_exponent};
         X_SE: move_val = {{(DATA_W-EXPO_W){shift_exponent[EXPO_W-1]}}, shift_exponent};
         default: move_val = x_op;
      endcase
   end

   // File writes: moves and memory loads land at the end of the cycle.
   assign we = (ex.unit == U_LOAD) || (ex.unit == U_MOVE && ex.move_dst == D_REG);
   assign waddr = {ex_bank, ex.d_reg};
   assign wdata = (ex.unit != U_LOAD) ? move_val : (ex.bus == B_PM) ? pm_data_in : dm_data_in;

   ////////////////////////////////////////////////////////////////////////////
   // single-cycle units: all results form combinationally this cycle.
   always_comb
   begin
      next_mr = multiply_result;
      next_sr = shift_result;
      next_ar = alu_result;
      next_af = alu_feedback;
      next_se = shift_exponent;
      next_sb = shift_block_exponent;
      next_flags = arith_status_reg;
      alu_out = alu_calc(ex.alu_op, x_op, y_op, arith_status_reg.alu_carry_flag);
      // format bit: zero is fractional 1.15, one is integer 16.0.
      // 1.15 operands get the fractional adjustment.
      mul_full = mul_calc(x_op, y_op, ex.x_signed, ex.y_signed,
         !mode_status_reg[MMODE_BIT]);
      acc = ex.alt_dst ? shift_result : multiply_result;
      unique case (ex.unit)
         U_ALU:
         begin
            if (ex.alt_dst)
            begin
               next_af = alu_out.result;
            end
            else
            begin
               next_ar = alu_out.result;
            end
            next_flags = alu_out.flags;
         end
         U_MUL:
         begin
            unique case (ex.mul_op)
               M_MUL: acc = mul_full;
               M_MAC: acc = acc + mul_full;
               default: acc = acc - mul_full;
            endcase
            if (ex.round)
            begin
               acc = acc + ROUND_ADD;
            end
            if (ex.alt_dst)
            begin
               next_sr = acc;
            end
            else
            begin
               next_mr = acc;
            end
         end
         U_SHIFT:
         begin
            if (ex.shift_op == S_EXP)
            begin
               next_se = exp_detect(x_op);
            end
            else
            begin
               next_sr = shift_calc(x_op, shift_exponent, ex.shift_op == S_ASH);
            end
         end
         U_MOVE:
         begin
            if (ex.move_dst == D_SB)
            begin
               next_sb = x_op[EXPO_W-1:0];
            end
            else if (ex.move_dst == D_SE)
            begin
               next_se = x_op[EXPO_W-1:0];
            end
         end
         default:
         begin
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // bank swap one cycle after the file bank, so in-flight results stay put.
   assign swap = (ex_bank != cur_bank);

   // result registers update at the end of the execution cycle.
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         cur_bank <= 1'b0;
         multiply_result <= ACC_ZERO;
         shift_result <= ACC_ZERO;
         alu_result <= WORD_ZERO;
         alu_feedback <= WORD_ZERO;
         shift_exponent <= EXPO_ZERO;
         shift_block_exponent <= EXPO_ZERO;
         mr_alt <= ACC_ZERO;
         sr_alt <= ACC_ZERO;
         ar_alt <= WORD_ZERO;
         af_alt <= WORD_ZERO;
         se_alt <= EXPO_ZERO;
         sb_alt <= EXPO_ZERO;
      end
      else if (swap)
      begin
         cur_bank <= ex_bank;
         multiply_result <= mr_alt;
         shift_result <= sr_alt;
         alu_result <= ar_alt;
         alu_feedback <= af_alt;
         shift_exponent <= se_alt;
         shift_block_exponent <= sb_alt;
         mr_alt <= next_mr;
         sr_alt <= next_sr;
         ar_alt <= next_ar;
         af_alt <= next_af;
         se_alt <= next_se;
         sb_alt <= next_sb;
      end
      else
      begin
         multiply_result <= next_mr;
         shift_result <= next_sr;
         alu_result <= next_ar;
         alu_feedback <= next_af;
         shift_exponent <= next_se;
         shift_block_exponent <= next_sb;
      end
   end

   // Status flags and the store path to the memory buses.
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         arith_status_reg <= '0;
         bus_data_out <= WORD_ZERO;
         bus_data_valid <= 1'b0;
         bus_data_sel <= B_DM;
      end
      else
      begin
         arith_status_reg <= next_flags;
         bus_data_valid <= (ex.unit == U_STORE);
         if (ex.unit == U_STORE)
         begin
            bus_data_out <= rd_x;
            bus_data_sel <= ex.bus;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checking helpers; the add and product references are independent of the datapath functions.
   assign add_chk = {1'b0, x_op} + {1'b0, y_op};
   assign add_carry = add_chk[DATA_W];
   assign prod_chk = $signed(x_op) * $signed(y_op);
   assign alu_res = alu_out.result;
   assign ex_dreg = ex.d_reg;

   sequence alu_add_q;
      ex.unit == U_ALU && ex.alu_op == A_ADD;
   endsequence
   sequence mul_plain_q;
      ex.unit == U_MUL && ex.mul_op == M_MUL && !ex.round && !ex.alt_dst && !swap &&
         ex.x_signed && ex.y_signed;
   endsequence
   sequence ar_write_q;
      ex.unit == U_ALU && !ex.alt_dst && !swap;
   endsequence
   sequence dm_load_q;
      ex.unit == U_LOAD && ex.bus == B_DM;
   endsequence

   add_overflow_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      alu_add_q ##0 (x_op[DATA_W-1] == y_op[DATA_W-1] && add_chk[DATA_W-1] != x_op[DATA_W-1])
      |=> arith_status_reg.alu_overflow_flag) else $error("overflow not flagged");
   mixed_sign_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      alu_add_q ##0 (x_op[DATA_W-1] != y_op[DATA_W-1]) |=> !arith_status_reg.alu_overflow_flag)
      else $error("mixed-sign add flagged overflow");
   carry_out_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      alu_add_q |=> arith_status_reg.alu_carry_flag == $past(add_carry))
      else $error("carry flag wrong");
   logic_and_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (ex.unit == U_ALU && ex.alu_op == A_AND && !ex.alt_dst && !swap)
      |=> alu_result == ($past(x_op) & $past(y_op))) else $error("AND result wrong");
   frac_mul_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      mul_plain_q ##0 !mode_status_reg[MMODE_BIT]
      |=> multiply_result[0] == 1'b0 && multiply_result[PROD_W:1] == $past(prod_chk))
      else $error("fractional product not shifted");
   int_mul_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      mul_plain_q ##0 mode_status_reg[MMODE_BIT]
      |=> multiply_result[PROD_W-1:0] == $past(prod_chk)) else $error("integer product wrong");
   sign_ext_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      mul_plain_q ##0 mode_status_reg[MMODE_BIT]
      |=> (&multiply_result[ACC_W-1:PROD_W-1]) || !(|multiply_result[ACC_W-1:PROD_W-1]))
      else $error("product not sign-extended");
   ar_feedback_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ar_write_q ##1 (ex.x_src == X_AR && !swap) |-> x_op == $past(alu_res))
      else $error("ALU result not fed back");
   bank_swap_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      swap |=> multiply_result == $past(mr_alt) && alu_result == $past(ar_alt))
      else $error("secondary set not restored");
   load_use_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      dm_load_q ##1 (ex.x_reg == $past(ex_dreg) && ex_bank == $past(ex_bank))
      |-> rd_x == $past(dm_data_in)) else $error("loaded word not read back");
   // shifter-only registers stay off the operand path.
   no_expo_op_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (ex.unit == U_ALU && ex.alu_op == A_PASS && !ex.alt_dst && !swap &&
         ex.x_src inside {X_SB, X_SE}) |=> alu_result == $past(rd_x))
      else $error("exponent used as operand");
endmodule

// File: sim/dm_model.sv
// Data-memory partner that keeps one word written by stores.
`timescale 1ns/1ps
module dm_model
(
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst_n,
   // Store side of the data-memory bus.
   input wire logic [compute_pkg::DATA_W-1:0] bus_data_out,
   input wire logic bus_data_valid,
   input compute_pkg::bus_e bus_data_sel,
   // Load side.
   output logic [compute_pkg::DATA_W-1:0] dm_data_in
);
   import compute_pkg::*;

   logic [DATA_W-1:0] word;

   //////////////////////////////////////////////////////////////////
   // memory bus port.
   // Only stores aimed at this bus land here, so a misrouted store shows up on reload.
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         word <= WORD_ZERO;
      end
      else if (bus_data_valid && bus_data_sel == B_DM)
      begin
         word <= bus_data_out;
      end
   end
   assign dm_data_in = word; // Held for any later load.
endmodule

// File: sim/tb_top.sv
// Self-checking bench for the compute units.
`timescale 1ns/1ps
module tb_top;
   import compute_pkg::*;
   logic ref_clk;
   logic rst_n;
   instr_s instr;
   logic [DATA_W-1:0] mode_status_reg;
   logic [DATA_W-1:0] pm_data_in;
   logic [DATA_W-1:0] dm_data_in;
   logic [DATA_W-1:0] bus_data_out;
   logic bus_data_valid;
   bus_e bus_data_sel;
   flags_s arith_status_reg;
   logic [ACC_W-1:0] multiply_result;
   logic [ACC_W-1:0] shift_result;
   logic [DATA_W-1:0] alu_result;
   logic [DATA_W-1:0] alu_feedback;
   logic [EXPO_W-1:0] shift_exponent;
   logic [EXPO_W-1:0] shift_block_exponent;
   logic secondary_sel;
   int compares;
   int mismatches;
   instr_s t;
   instr_s u;
   alu_op_e lops [4] = '{A_AND, A_OR, A_XOR, A_NOT};
   logic [DATA_W-1:0] lexp [4] = '{16'h0001, 16'h7FFF, 16'h7FFE, 16'h8000};

   //////////////////////////////////////////////////////////////////
   // Design and partner.
   fixed_point_compute_units fixed_point_compute_units_i (.ref_clk(ref_clk), .rst_n(rst_n),
      .instr(instr), .secondary_sel(secondary_sel), .mode_status_reg(mode_status_reg),
      .pm_data_in(pm_data_in), .dm_data_in(dm_data_in), .bus_data_out(bus_data_out),
      .bus_data_valid(bus_data_valid), .bus_data_sel(bus_data_sel),
      .arith_status_reg(arith_status_reg), .multiply_result(multiply_result),
      .shift_result(shift_result), .alu_result(alu_result), .alu_feedback(alu_feedback),
      .shift_exponent(shift_exponent), .shift_block_exponent(shift_block_exponent));
   dm_model dm_model_i (.ref_clk(ref_clk), .rst_n(rst_n), .bus_data_out(bus_data_out),
      .bus_data_valid(bus_data_valid), .bus_data_sel(bus_data_sel), .dm_data_in(dm_data_in));

   // The 40 MHz core clock.
   initial
   begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   //////////////////////////////////////////////////////////////////
   // Instruction builder; signed operands and the program bus by default.
   function automatic instr_s mk(unit_e u, alu_op_e a, logic [3:0] x, y, d);
      mk = '0;
      mk.unit = u;
      mk.alu_op = a;
      mk.x_reg = x;
      mk.y_reg = y;
      mk.d_reg = d;
      mk.x_signed = 1'b1;
      mk.y_signed = 1'b1;
      mk.bus = B_PM;
   endfunction

   // Issue one instruction, then idle until its results are settled.
   task automatic ex(instr_s i);
      @(posedge ref_clk);
      instr <= i;
      @(posedge ref_clk);
      instr <= mk(U_NOP, A_ADD, 0, 0, 0);
      @(posedge ref_clk);
      #1;
   endtask

   // Issue two instructions back to back, so the second uses the first's result.
   task automatic ex2(instr_s a, instr_s b);
      @(posedge ref_clk);
      instr <= a;
      ex(b);
   endtask

   // Load a file register from the program bus.
   task automatic ld(logic [3:0] r, logic [DATA_W-1:0] v);
      @(posedge ref_clk);
      pm_data_in <= v;
      ex(mk(U_LOAD, A_ADD, 0, 0, r));
   endtask

   task automatic chk(string n, logic [ACC_W-1:0] s, logic [ACC_W-1:0] e);
      compares++;
      if (s !== e)
      begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic print_verdict();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   //////////////////////////////////////////////////////////////////
   // Main sequence; results are read two cycles after the issue edge.
   initial
   begin
      compares = 0;
      mismatches = 0;
      rst_n = 1'b0;
      instr = mk(U_NOP, A_ADD, 0, 0, 0);
      mode_status_reg = 16'h0000;
      pm_data_in = 16'h0000;
      secondary_sel = 1'b0;
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      chk("reset flags", arith_status_reg, 4'h0);
      ld(1, 16'h7FFF);
      ld(2, 16'h0001);
      ld(3, 16'hFFFF);
      ld(4, 16'h8000);
      ld(5, 16'h4000);
      ex(mk(U_ALU, A_ADD, 1, 2, 0));
      chk("add sum", alu_result, 16'h8000);
      chk("add flags", arith_status_reg, 4'h6);
      ex(mk(U_ALU, A_ADD, 3, 2, 0));
      chk("wrap sum", alu_result, 16'h0000);
      chk("wrap flags", arith_status_reg, 4'h9);
      ex(mk(U_ALU, A_ADDC, 2, 2, 0));
      chk("upper word", alu_result, 16'h0003);
      for (int k = 0; k < 4; k++)
      begin
         ex(mk(U_ALU, lops[k], 1, 2, 0));
         chk("logic op", alu_result, lexp[k]);
      end
      t = mk(U_ALU, A_ADD, 0, 2, 0);
      t.x_src = X_AR;
      ex2(mk(U_ALU, A_ADD, 1, 2, 0), t);
      chk("ar fed back", alu_result, 16'h8001);
      ex(mk(U_ALU, A_SUB, 2, 1, 0));
      chk("sub result", alu_result, 16'h8002);
      chk("sub flags", arith_status_reg, 4'h4);
      // Secondary result set starts cleared; the primary set comes back intact.
      @(posedge ref_clk);
      secondary_sel <= 1'b1;
      ex(mk(U_NOP, A_ADD, 0, 0, 0));
      chk("secondary ar", alu_result, 16'h0000);
      @(posedge ref_clk);
      secondary_sel <= 1'b0;
      ex(mk(U_NOP, A_ADD, 0, 0, 0));
      chk("primary ar", alu_result, 16'h8002);
      $display("test alu done");
      ex(mk(U_MUL, A_ADD, 4, 5, 0));
      chk("frac product", multiply_result, 40'hFF_C000_0000);
      @(posedge ref_clk);
      mode_status_reg <= 16'h0010;
      ex(mk(U_MUL, A_ADD, 4, 5, 0));
      chk("int product", multiply_result, 40'hFF_E000_0000);
      t = mk(U_MUL, A_ADD, 4, 5, 0);
      t.x_signed = 1'b0;
      t.y_signed = 1'b0;
      u = mk(U_ALU, A_ADD, 0, 2, 0);
      u.x_src = X_MR_MID;
      ex2(t, u);
      chk("unsigned product", multiply_result, 40'h00_2000_0000);
      chk("fed back sum", alu_result, 16'h2001);
      $display("test multiplier done");
      t = mk(U_MOVE, A_ADD, 2, 0, 0);
      t.move_dst = D_SE;
      ex(t);
      chk("se move", shift_exponent, 8'h01);
      t = mk(U_MOVE, A_ADD, 3, 0, 0);
      t.move_dst = D_SB;
      ex(t);
      chk("sb move", shift_block_exponent, 8'hFF);
      t = mk(U_SHIFT, A_ADD, 4, 0, 0);
      ex(t);
      chk("logical shift", shift_result, 40'h00_0001_0000);
      t.shift_op = S_ASH;
      ex(t);
      chk("arith shift", shift_result, 40'hFF_FFFF_0000);
      t = mk(U_SHIFT, A_ADD, 2, 0, 0);
      t.shift_op = S_EXP;
      ex(t);
      chk("exponent", shift_exponent, 8'hF2);
      t = mk(U_ALU, A_PASS, 5, 0, 0);
      t.x_src = X_SE;
      ex(t);
      chk("se not operand", alu_result, 16'h4000);
      t = mk(U_MOVE, A_ADD, 0, 0, 8);
      t.x_src = X_SE;
      ex(t);
      ex(mk(U_ALU, A_PASS, 8, 0, 0));
      chk("se to file", alu_result, 16'hFFF2);
      $display("test shifter done");
      t = mk(U_STORE, A_ADD, 1, 0, 0);
      t.bus = B_DM;
      ex(t);
      chk("store valid", bus_data_valid, 1'b1);
      chk("store word", bus_data_out, 16'h7FFF);
      chk("store bus", bus_data_sel, B_DM);
      @(posedge ref_clk);
      #1;
      chk("valid pulse", bus_data_valid, 1'b0);
      t = mk(U_LOAD, A_ADD, 0, 0, 6);
      t.bus = B_DM;
      ex2(t, mk(U_STORE, A_ADD, 6, 0, 0));
      chk("reload word", bus_data_out, 16'h7FFF);
      chk("reload bus", bus_data_sel, B_PM);
      $display("test memory done");
      print_verdict();
   end
endmodule
